// ===== rtl/shcm_pkg.sv
// constants and types shared by the sensor host command mailbox
package shcm_pkg;

  // ==========================================================
  // register offsets, byte addressed
  localparam logic [7:0] SHCM_OFF_P3TH_LOW  = 8'h15;
  localparam logic [7:0] SHCM_OFF_P3TH_HIGH = 8'h16;
  localparam logic [7:0] SHCM_OFF_MAILBOX   = 8'h17;
  localparam logic [7:0] SHCM_OFF_COMMAND   = 8'h18;
  localparam logic [7:0] SHCM_OFF_RESPONSE  = 8'h20;

  // ==========================================================
  // reset values and read value of unmapped locations
  localparam logic [7:0] SHCM_RST_BYTE      = 8'h00;
  localparam logic [7:0] SHCM_UNMAPPED_RD   = 8'h00;

  // ==========================================================
  // response codes, the top bit marks an error
  localparam int         SHCM_ERR_BIT       = 7;
  localparam int         SHCM_CNT_W         = 4;
  localparam logic [7:0] SHCM_ERR_INVALID   = 8'h80;
  localparam logic [7:0] SHCM_ERR_OVF_P1    = 8'h88;
  localparam logic [7:0] SHCM_ERR_OVF_P2    = 8'h89;
  localparam logic [7:0] SHCM_ERR_OVF_P3    = 8'h8A;
  localparam logic [7:0] SHCM_ERR_OVF_VIS   = 8'h8C;

  // ==========================================================
  // command codes the mailbox handles itself
  localparam logic [7:0] SHCM_OP_NOP        = 8'h00;
  localparam logic [7:0] SHCM_OP_RESET      = 8'h01;

  // ==========================================================
  // compressed threshold layout: exponent high nibble, mantissa low nibble
  localparam int         SHCM_CMP_EXP_LSB   = 4;
  localparam int         SHCM_CMP_MAN_W     = 4;
  localparam logic [3:0] SHCM_CMP_EXP_MAX   = 4'hB;
  localparam int         SHCM_THR_W         = 16;

  // ==========================================================
  // command path states
  typedef enum logic [1:0] {
    SHCM_IDLE,
    SHCM_HOLD,
    SHCM_EXEC
  } shcm_state_t;

  // all state of the mailbox
  typedef struct packed {
    shcm_state_t st;
    logic [7:0]  th_low;
    logic [7:0]  th_high;
    logic [7:0]  mailbox;
    logic [7:0]  cmd;
    logic [7:0]  resp;
    logic [7:0]  rdata;
    logic        cmd_strobe;
    logic        wake;
    logic        seq_rst;
  } shcm_regs_t;

  // state of the threshold comparator
  typedef struct packed {
    logic alert;
  } shcm_cmp_t;

endpackage

// ===== rtl/shcm_thresh_cmp.sv
// third proximity channel threshold comparator
`timescale 1ns/1ps
module shcm_thresh_cmp
  import shcm_pkg::*;
#(
  parameter int  THR_W      = SHCM_THR_W,
  parameter bit  COMPRESSED = 1'b0
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             clk_en,
  input  wire logic [7:0]       th_low,
  input  wire logic [7:0]       th_high,
  input  wire logic [THR_W-1:0] result,
  input  wire logic             result_valid,
  output logic                  alert
);

  // ==========================================================
  // elaboration check
  if (THR_W != SHCM_THR_W) begin : g_bad_width
    $error("shcm_thresh_cmp: threshold width must be 16");
  end

  // ==========================================================
  // compressed byte to full threshold: {1,mantissa} shifted by exponent
  function automatic logic [THR_W-1:0] shcm_expand(input logic [7:0] c);
    logic [3:0]       e;
    logic [THR_W-1:0] v;
    e = c[SHCM_CMP_EXP_LSB +: 4];
    if (e > SHCM_CMP_EXP_MAX) begin
      e = SHCM_CMP_EXP_MAX;
    end
    v = THR_W'({1'b1, c[SHCM_CMP_MAN_W-1:0]});
    shcm_expand = v << e;
  endfunction

  shcm_cmp_t        q_r;
  shcm_cmp_t        q_nxt;
  logic [THR_W-1:0] thr;

  // in full mode both bytes are used live, so a half-written update is seen as is
  assign thr = COMPRESSED ? shcm_expand(th_low) : {th_high, th_low};

  // alert pulse for a result beyond the threshold
  always_comb begin
    q_nxt       = q_r;
    q_nxt.alert = result_valid && (result > thr);
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      q_r <= '0;
    end else if (clk_en) begin
      q_r <= q_nxt;
    end
  end

  assign alert = q_r.alert;

endmodule

// ===== rtl/shcm_top.sv
// sensor host command mailbox: threshold, parameter and command registers
//
// Behaviour
// - compare third proximity result with 16-bit threshold
// - threshold high byte read/write at 0x16
// - half-updated threshold may be applied mixed
// - early revision: one compressed byte at 0x15
// - parameter mailbox at 0x17, resets to zero
// - write to 0x18 queues one command; a later write before issue replaces it, one during execution is lost
// - only command writes wake from standby
// - errors load response with top bit set
// - error held until reset or no-operation command; a host write to 0x20, or a command finishing with cmd_bad (0x80), also overwrites it
// - while error held, other commands ignored
// - autonomous measurements continue despite held error
// - no error: low nibble counts completed commands
// - engine command issue waits for running measurement; reset and no-operation complete without waiting
// - unknown command reports code 0x80
// - proximity overflow codes 0x88, 0x89, 0x8A
// - visible light overflow reports code 0x8C
`timescale 1ns/1ps
module shcm_top
  import shcm_pkg::*;
#(
  parameter int  THR_W      = SHCM_THR_W,
  parameter bit  COMPRESSED = 1'b0
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             clk_en,
  // register access from the serial front end
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  // sequencer and measurement engine
  input  wire logic             meas_busy,
  input  wire logic             cmd_done,
  input  wire logic             cmd_bad,
  input  wire logic             ovf_prox1,
  input  wire logic             ovf_prox2,
  input  wire logic             ovf_prox3,
  input  wire logic             ovf_visible,
  input  wire logic [THR_W-1:0] prox3_result,
  input  wire logic             prox3_result_valid,
  output logic                  cmd_strobe,
  output logic      [7:0]       cmd_code,
  output logic      [7:0]       param_value,
  output logic                  wake_pulse,
  output logic                  seq_reset,
  output logic                  prox3_alert,
  output logic      [7:0]       response
);

  // ==========================================================
  // elaboration check
  if (THR_W != SHCM_THR_W) begin : g_bad_width
    $error("shcm_top: threshold width must be 16");
  end

  // ==========================================================
  // helpers

  // next counter value; wraps at fifteen and keeps the top clear
  function automatic logic [7:0] shcm_count_up(input logic [7:0] r);
    logic [SHCM_CNT_W-1:0] c;
    c = r[SHCM_CNT_W-1:0] + SHCM_CNT_W'(1);
    shcm_count_up = {{(8 - SHCM_CNT_W){1'b0}}, c};
  endfunction

  // true when the response holds an error code
  function automatic logic shcm_is_err(input logic [7:0] r);
    shcm_is_err = r[SHCM_ERR_BIT];
  endfunction

  // true when a host write hits the given offset
  function automatic logic shcm_hit(input logic       wr,
                                    input logic [7:0] a,
                                    input logic [7:0] off);
    shcm_hit = wr && (a == off);
  endfunction

  // ==========================================================
  // state
  shcm_regs_t q_r;
  shcm_regs_t q_nxt;

  logic       wr_th_low;
  logic       wr_th_high;
  logic       wr_mailbox;
  logic       wr_command;
  logic       wr_response;
  logic       is_self_cmd;
  logic       any_ovf;
  logic [7:0] ovf_code;

  // write decode; high byte is absent when the threshold is compressed
  assign wr_th_low   = shcm_hit(reg_wr, reg_addr, SHCM_OFF_P3TH_LOW);
  assign wr_th_high  = shcm_hit(reg_wr, reg_addr, SHCM_OFF_P3TH_HIGH) && !COMPRESSED;
  assign wr_mailbox  = shcm_hit(reg_wr, reg_addr, SHCM_OFF_MAILBOX);
  assign wr_command  = shcm_hit(reg_wr, reg_addr, SHCM_OFF_COMMAND);
  assign wr_response = shcm_hit(reg_wr, reg_addr, SHCM_OFF_RESPONSE);

  // reset and no-operation are finished here without the engine
  assign is_self_cmd = (q_r.cmd == SHCM_OP_NOP) || (q_r.cmd == SHCM_OP_RESET);

  // ==========================================================
  // overflow code select, fixed priority when several coincide
  always_comb begin
    any_ovf  = 1'b1;
    ovf_code = SHCM_ERR_OVF_P1;
    if (ovf_prox1) begin
      ovf_code = SHCM_ERR_OVF_P1;
    end else if (ovf_prox2) begin
      ovf_code = SHCM_ERR_OVF_P2;
    end else if (ovf_prox3) begin
      ovf_code = SHCM_ERR_OVF_P3;
    end else if (ovf_visible) begin
      ovf_code = SHCM_ERR_OVF_VIS;
    end else begin
      any_ovf  = 1'b0;
    end
  end

  // ==========================================================
  // next-state logic
  always_comb begin
    q_nxt            = q_r;
    q_nxt.cmd_strobe = 1'b0;
    q_nxt.wake       = 1'b0;
    q_nxt.seq_rst    = 1'b0;

    // plain register writes; none of these wakes the device
    if (wr_th_low) begin
      q_nxt.th_low = reg_wdata;
    end
    if (wr_th_high) begin
      q_nxt.th_high = reg_wdata;
    end
    if (wr_mailbox) begin
      q_nxt.mailbox = reg_wdata;
    end
    if (wr_response) begin
      q_nxt.resp = reg_wdata;
    end

    // command path
    case (q_r.st)
      SHCM_IDLE: begin
        q_nxt.st = SHCM_IDLE;
      end
      SHCM_HOLD: begin
        if (is_self_cmd) begin
          // reset and no-operation are the only ones that clear an error
          if (q_r.cmd == SHCM_OP_RESET) begin
            q_nxt.resp    = SHCM_RST_BYTE;
            q_nxt.seq_rst = 1'b1;
          end else if (shcm_is_err(q_r.resp)) begin
            q_nxt.resp = SHCM_RST_BYTE;
          end else begin
            q_nxt.resp = shcm_count_up(q_r.resp);
          end
          q_nxt.st = SHCM_IDLE;
        end else if (shcm_is_err(q_r.resp)) begin
          // dropped silently, the counter does not move
          q_nxt.st = SHCM_IDLE;
        end else if (!meas_busy) begin
          // a running measurement delays issue, so timing is not fixed
          q_nxt.cmd_strobe = 1'b1;
          q_nxt.st         = SHCM_EXEC;
        end else begin
          q_nxt.st = SHCM_HOLD;
        end
      end
      SHCM_EXEC: begin
        if (cmd_done) begin
          if (cmd_bad) begin
            q_nxt.resp = SHCM_ERR_INVALID;
          end else if (!shcm_is_err(q_r.resp)) begin
            q_nxt.resp = shcm_count_up(q_r.resp);
          end
          q_nxt.st = SHCM_IDLE;
        end
      end
      default: begin
        q_nxt.st = SHCM_IDLE;
      end
    endcase

    // a host command write always lands; it is queued for the sequencer unless one is executing
    if (wr_command) begin
      q_nxt.cmd  = reg_wdata;
      q_nxt.wake = 1'b1;
      if (q_r.st != SHCM_EXEC) begin
        q_nxt.st = SHCM_HOLD;
      end
    end

    // overflow wins over any clear in the same cycle; the first error is kept
    // so the host sees the cause, and measurements are not stopped by it
    if (any_ovf && !shcm_is_err(q_r.resp)) begin
      q_nxt.resp = ovf_code;
    end else if (any_ovf && shcm_is_err(q_nxt.resp) == 1'b0) begin
      q_nxt.resp = ovf_code;
    end

    // read data, registered one cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        SHCM_OFF_P3TH_LOW: begin
          q_nxt.rdata = q_r.th_low;
        end
        SHCM_OFF_P3TH_HIGH: begin
          q_nxt.rdata = COMPRESSED ? SHCM_UNMAPPED_RD : q_r.th_high;
        end
        SHCM_OFF_MAILBOX: begin
          q_nxt.rdata = q_r.mailbox;
        end
        SHCM_OFF_COMMAND: begin
          q_nxt.rdata = q_r.cmd;
        end
        SHCM_OFF_RESPONSE: begin
          q_nxt.rdata = q_r.resp;
        end
        default: begin
          q_nxt.rdata = SHCM_UNMAPPED_RD;
        end
      endcase
    end
  end

  // ==========================================================
  // state register, frozen while the clock enable is low
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      q_r.st         <= SHCM_IDLE;
      q_r.th_low     <= SHCM_RST_BYTE;
      q_r.th_high    <= SHCM_RST_BYTE;
      q_r.mailbox    <= SHCM_RST_BYTE;
      q_r.cmd        <= SHCM_RST_BYTE;
      q_r.resp       <= SHCM_RST_BYTE;
      q_r.rdata      <= SHCM_RST_BYTE;
      q_r.cmd_strobe <= 1'b0;
      q_r.wake       <= 1'b0;
      q_r.seq_rst    <= 1'b0;
    end else if (clk_en) begin
      q_r <= q_nxt;
    end
  end

  // ==========================================================
  // threshold comparator for the third proximity channel
  shcm_thresh_cmp #(
    .THR_W      (THR_W),
    .COMPRESSED (COMPRESSED)
  ) u_cmp (
    .core_clk     (core_clk),
    .nrst         (nrst),
    .clk_en       (clk_en),
    .th_low       (q_r.th_low),
    .th_high      (q_r.th_high),
    .result       (prox3_result),
    .result_valid (prox3_result_valid),
    .alert        (prox3_alert)
  );

  // ==========================================================
  // outputs, all straight from flops
  assign reg_rdata   = q_r.rdata;
  assign cmd_strobe  = q_r.cmd_strobe;
  assign cmd_code    = q_r.cmd;
  assign param_value = q_r.mailbox;
  assign wake_pulse  = q_r.wake;
  assign seq_reset   = q_r.seq_rst;
  assign response    = q_r.resp;

endmodule

// ===== tb/shcm_engine_model.sv
// stand-in for the sequencer engine behind the command path
`timescale 1ns/1ps
module shcm_engine_model (
  input  wire logic       core_clk,
  input  wire logic       cmd_strobe,
  input  wire logic [7:0] cmd_code,
  input  wire logic [3:0] lat,
  output logic            cmd_done,
  output logic            cmd_bad
);
  logic [4:0] cnt_r = 5'h00;
  logic [7:0] code_r;
  initial cmd_done = 1'b0;
  initial cmd_bad = 1'b0;
  // ==========================================================
  // one command in flight; latency varies so completion time is not fixed
  always @(posedge core_clk) begin
    cmd_done <= 1'b0;
    cmd_bad  <= 1'b0;
    if (cmd_strobe) begin
      cnt_r  <= {1'b0, lat} + 5'h01;
      code_r <= cmd_code;
    end else if (cnt_r == 5'h01) begin
      cmd_done <= 1'b1;
      cmd_bad  <= code_r >= 8'h40;
      cnt_r    <= 5'h00;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end
endmodule

// ===== tb/shcm_monitor.sv
// port assertions for the command mailbox
`timescale 1ns/1ps
module shcm_monitor
  import shcm_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       clk_en,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       cmd_done,
  input wire logic       cmd_bad,
  input wire logic       ovf_prox1,
  input wire logic       ovf_prox2,
  input wire logic       ovf_prox3,
  input wire logic       ovf_visible,
  input wire logic       cmd_strobe,
  input wire logic [7:0] param_value,
  input wire logic       wake_pulse,
  input wire logic       seq_reset,
  input wire logic [7:0] response
);
  logic [3:0] cnt_nxt;
  logic       quiet;
  // ==========================================================
  // helpers; quiet excludes events whose priority is left open
  assign cnt_nxt = response[3:0] + 4'h1;
  assign quiet = !ovf_prox1 && !ovf_prox2 && !ovf_prox3 && !(reg_wr && reg_addr == SHCM_OFF_RESPONSE);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst || !clk_en);
  sequence s_cmd_wr;
    reg_wr && reg_addr == SHCM_OFF_COMMAND;
  endsequence
  sequence s_rst_wr;
    s_cmd_wr ##0 reg_wdata == SHCM_OP_RESET;
  endsequence
  a_cmd_wakes: assert property (s_cmd_wr |=> wake_pulse) else $error("no wake after command write");
  a_only_cmd_wakes: assert property (wake_pulse |-> $past(reg_wr && reg_addr == SHCM_OFF_COMMAND))
    else $error("wake without command write");
  a_mailbox_load: assert property (reg_wr && reg_addr == SHCM_OFF_MAILBOX |=> param_value == $past(reg_wdata))
    else $error("mailbox not loaded");
  a_count_step: assert property (cmd_done && !cmd_bad && !response[7] && quiet
    |=> response == {4'h0, $past(cnt_nxt)}) else $error("counter did not step");
  a_bad_code: assert property (cmd_done && cmd_bad && !response[7] && quiet |=> response == SHCM_ERR_INVALID)
    else $error("bad command code not reported");
  a_ovf_first: assert property (ovf_prox1 && !cmd_done && !response[7]
    && !(reg_wr && reg_addr == SHCM_OFF_RESPONSE) |=> response == SHCM_ERR_OVF_P1)
    else $error("first channel overflow code wrong");
  a_ovf_visible: assert property (ovf_visible && !cmd_done && !response[7] && quiet
    |=> response == SHCM_ERR_OVF_VIS) else $error("visible overflow code wrong");
  a_err_holds: assert property (response[7] && !reg_wr && !$past(reg_wr) |=> $stable(response))
    else $error("error code changed");
  a_err_blocks: assert property (s_cmd_wr ##0 (reg_wdata > SHCM_OP_RESET && response[7]) |=> !cmd_strobe [*3])
    else $error("command issued while error held");
  a_reset_clears: assert property (s_rst_wr |-> ##2 response == SHCM_RST_BYTE)
    else $error("reset command left response");
  a_reset_pulse: assert property (s_rst_wr |-> ##[1:3] seq_reset) else $error("no sequencer reset");
endmodule
bind shcm_top shcm_monitor u_mon (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .cmd_done(cmd_done), .cmd_bad(cmd_bad), .ovf_prox1(ovf_prox1),
  .ovf_prox2(ovf_prox2), .ovf_prox3(ovf_prox3), .ovf_visible(ovf_visible), .cmd_strobe(cmd_strobe),
  .param_value(param_value), .wake_pulse(wake_pulse), .seq_reset(seq_reset), .response(response));

// ===== tb/shcm_top_tb.sv
// self-checking bench for the command mailbox
`timescale 1ns/1ps
module shcm_top_tb;
  import shcm_pkg::*;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        meas_busy = 1'b0;
  logic        res_v = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [3:0]  ovf_v = 4'h0;
  logic [3:0]  lat = 4'h0;
  logic [15:0] res = 16'h0000;
  logic [15:0] thr;
  logic [7:0]  reg_rdata, cmd_code, param_value, response, v, d;
  logic [7:0]  ovf_code [4] = '{SHCM_ERR_OVF_P1, SHCM_ERR_OVF_P2, SHCM_ERR_OVF_P3, SHCM_ERR_OVF_VIS};
  logic [3:0]  cnt;
  logic        cmd_done, cmd_bad, cmd_strobe, wake_pulse, seq_reset, prox3_alert;
  integer      seed = 32'hB01010D8;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cyc = 0;
  shcm_top dut (.core_clk(core_clk), .nrst(nrst), .clk_en(1'b1), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .meas_busy(meas_busy),
    .cmd_done(cmd_done), .cmd_bad(cmd_bad), .ovf_prox1(ovf_v[0]), .ovf_prox2(ovf_v[1]), .ovf_prox3(ovf_v[2]),
    .ovf_visible(ovf_v[3]), .prox3_result(res), .prox3_result_valid(res_v), .cmd_strobe(cmd_strobe),
    .cmd_code(cmd_code), .param_value(param_value), .wake_pulse(wake_pulse), .seq_reset(seq_reset),
    .prox3_alert(prox3_alert), .response(response));
  shcm_engine_model u_eng (.core_clk(core_clk), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .lat(lat),
    .cmd_done(cmd_done), .cmd_bad(cmd_bad));
  // ==========================================================
  // clock and hang guard, sized well above the several hundred cycles used
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ==========================================================
  // byte register accesses, strobe held one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] b);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= b;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  // a command with random busy and engine latency; polls the counter, no fixed delay
  task automatic cmd(input logic [7:0] c);
    logic [7:0] old;
    int t;
    rd(SHCM_OFF_RESPONSE, old);
    meas_busy <= 1'($random(seed));
    lat <= 4'($random(seed));
    wr(SHCM_OFF_COMMAND, c);
    repeat (4) @(posedge core_clk);
    meas_busy <= 1'b0;
    t = 0;
    d = old;
    while (d === old && t < 40) begin
      rd(SHCM_OFF_RESPONSE, d);
      t++;
    end
  endtask
  task automatic pulse(input logic [15:0] r, input logic exp);
    @(posedge core_clk);
    res <= r;
    res_v <= 1'b1;
    @(posedge core_clk);
    res_v <= 1'b0;
    #1 chk({7'h00, prox3_alert}, {7'h00, exp});
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    rd(SHCM_OFF_MAILBOX, d);
    chk(d, SHCM_RST_BYTE);
    for (int k = 0; k < 4; k++) begin
      v = 8'($random(seed));
      wr(SHCM_OFF_MAILBOX, v);
      rd(SHCM_OFF_MAILBOX, d);
      chk(d, v);
      chk(param_value, v);
      wr(SHCM_OFF_P3TH_HIGH, ~v);
      rd(SHCM_OFF_P3TH_HIGH, d);
      chk(d, ~v);
    end
    wr(8'h30, 8'h5A);
    rd(8'h30, d);
    chk(d, SHCM_UNMAPPED_RD);
    cnt = 4'h0;
    for (int k = 0; k < 18; k++) begin
      v = (k == 5) ? SHCM_OP_NOP : 8'h02 + 8'($unsigned($random(seed)) % 62);
      cmd(v);
      cnt = cnt + 4'h1;
      chk(d, {4'h0, cnt});
      chk(cmd_code, v);
    end
    cmd(8'h55);
    chk(d, SHCM_ERR_INVALID);
    cmd(8'h05);
    chk(d, SHCM_ERR_INVALID);
    cmd(SHCM_OP_NOP);
    chk(d, 8'h00);
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      ovf_v <= 4'h1 << k;
      @(posedge core_clk);
      ovf_v <= 4'h0;
      rd(SHCM_OFF_RESPONSE, d);
      chk(d, ovf_code[k]);
      thr = {1'b0, 15'($random(seed))};
      wr(SHCM_OFF_P3TH_LOW, thr[7:0]);
      wr(SHCM_OFF_P3TH_HIGH, thr[15:8]);
      pulse(thr, 1'b0);
      pulse(thr + 16'h0001, 1'b1);
      cmd(SHCM_OP_RESET);
      chk(d, 8'h00);
    end
    tally_and_finish();
  end
endmodule
